// ---- rtl/afc_pkg.sv ----
// Purpose: Shared constants, register map and configuration and status types of the AFC, rate and modulation control
// Assumes: 7-bit register addresses with 8-bit data, one 200 MHz clock
// Notes:   Correction and offset words count in steps of 156.25 Hz times (band_high + 1)
package afc_pkg;

  localparam int MCLK_HZ     = 200_000_000;
  localparam int REF_TICK_HZ = 1_000_000;
  localparam int REF_DIV     = MCLK_HZ / REF_TICK_HZ;

  localparam logic [6:0] ADDR_LIMIT   = 7'h2A;
  localparam logic [6:0] ADDR_CORR    = 7'h2B;
  localparam logic [6:0] ADDR_RATE_HI = 7'h6E;
  localparam logic [6:0] ADDR_RATE_LO = 7'h6F;
  localparam logic [6:0] ADDR_MOD2    = 7'h71;
  localparam logic [6:0] ADDR_DEV     = 7'h72;
  localparam logic [6:0] ADDR_OFS_LO  = 7'h73;
  localparam logic [6:0] ADDR_OFS_HI  = 7'h74;

  localparam logic [7:0] RST_LIMIT   = 8'h00;
  localparam logic [7:0] RST_RATE_HI = 8'h0A;
  localparam logic [7:0] RST_RATE_LO = 8'h3D;
  localparam logic [7:0] RST_MOD2    = 8'h00;
  localparam logic [7:0] RST_DEV     = 8'h20;
  localparam logic [7:0] RST_OFS     = 8'h00;

  // Rate word divisor is 2^(RATE_BASE_SHIFT + RATE_SCALE_SHIFT * scale)
  localparam int RATE_BASE_SHIFT  = 16;
  localparam int RATE_SCALE_SHIFT = 5;

  // Bit periods of one measurement, and settle bit periods per wait step
  localparam logic [3:0] MEAS_BITS       = 4'h2;
  localparam logic [3:0] SETTLE_PER_WAIT = 4'h2;
  // Limiter step of 625 Hz is four correction steps of 156.25 Hz
  localparam int LIMIT_STEP_SHIFT = 2;
  localparam logic signed [11:0] CORR_MAX = 12'sh1FF;
  localparam logic signed [11:0] CORR_MIN = -12'sh200;

  localparam logic [8:0] PN9_SEED = 9'h1FF;

  typedef enum logic [1:0] {MOD_CARRIER, MOD_OOK, MOD_FSK, MOD_GFSK} afc_modtyp_t;
  typedef enum logic [1:0] {SRC_GPIO, SRC_SDI, SRC_FIFO, SRC_PN9} afc_src_t;

  typedef struct packed {
    logic [1:0]  trclk;
    afc_src_t    dtmod;
    logic        eninv;
    logic        dev_msb;
    afc_modtyp_t modtyp;
  } afc_mod_cfg_t;

  typedef struct packed {
    logic       rx_active;
    logic       tx_active;
    logic       preamble_det;
    logic       packet_end;
    logic       multi_packet;
    logic       rx_bit_tick;
  } afc_radio_t;

endpackage

// ---- rtl/afc_rate_gen.sv ----
// Purpose: Transmit bit-rate generator from a 1 MHz reference tick and a 16-bit rate word
// Assumes: Rate below the 1 MHz reference, so at most one carry per reference tick
// Notes:   Phase accumulator; carry position moves by five bits with the low-rate scale
`timescale 1ns/1ps
module afc_rate_gen #(
  parameter int RATE_W = 16
) (
  input  wire logic              mclk,
  input  wire logic              rst_b,
  input  wire logic              run,
  input  wire logic [RATE_W-1:0] rate_word,
  input  wire logic              low_scale,
  output logic                   bit_tick
);
  import afc_pkg::*;

  localparam int ACC_W  = RATE_BASE_SHIFT + RATE_SCALE_SHIFT + 1;
  localparam int CARRY0 = RATE_BASE_SHIFT;
  localparam int CARRY1 = RATE_BASE_SHIFT + RATE_SCALE_SHIFT;

  logic [7:0]       ref_cnt;
  logic             ref_tick;
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] sum;
  logic             carry;

  assign ref_tick = (ref_cnt == 8'(REF_DIV - 1));
  assign sum      = acc + ACC_W'(rate_word);
  assign carry    = low_scale ? sum[CARRY1] : sum[CARRY0];

  always_ff @(posedge mclk) begin
    if (!rst_b || ref_tick) begin
      ref_cnt <= 8'h00;
    end else begin
      ref_cnt <= ref_cnt + 8'h01;
    end
  end

  // Accumulator idles outside transmit so the first bit starts from phase zero
  always_ff @(posedge mclk) begin
    if (!rst_b || !run) begin
      acc <= '0;
    end else if (ref_tick) begin
      acc <= low_scale ? ACC_W'(sum[CARRY1-1:0]) : ACC_W'(sum[CARRY0-1:0]);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= run && ref_tick && carry;
    end
  end

  chk_tick_on_ref: assert property (@(posedge mclk) disable iff (!rst_b)
    bit_tick |-> $past(ref_tick) && $past(run)) else $error("rate tick without reference tick");
  chk_no_tick_idle: assert property (@(posedge mclk) disable iff (!rst_b)
    !run ##1 !run |-> !bit_tick) else $error("rate tick outside transmit");

endmodule

// ---- rtl/afc_rate_modulation_ctrl.sv ----
// Purpose: AFC loop, transmit rate generation and modulation selection with its register file
// Assumes: Modem supplies a signed error sample per receive bit tick; inputs synchronous to mclk
// Notes:   Registers sit at their printed addresses on a simple read/write strobe port
`timescale 1ns/1ps
// Functional notes
// - After preamble detection, correction is frozen until the packet ends.
// - In multi-packet receive, correction clears at each packet end and reacquires.
// - Pull-in range is limiter times (band+1) times 625 Hz.
// - Limiter value is unsigned.
// - Gear 000 applies full error; each increment halves the applied fraction.
// - Each cycle measures two bit periods, corrects, then settles.
// - Wait field sets cycle length; 001 gives four bit periods.
// - Wait field zero means no correction output.
// - Correction readable at 2Bh, step 156.25 Hz times (band+1).
// - AFC correction drives synthesizer only in receive with loop enabled.
// - Transmit rate programmable from 0.123 to 256 kbps.
// - Bit rate is rate word times 1 MHz over 2^(16+5*scale).
// - Rate word used only for transmit timing.
// - Modulation select: carrier, OOK, FSK, GFSK needing data clock in direct mode.
// - Data source select: GPIO, SDI while chip select high, buffer, PN9.
// - Band bit selects low or high band and scales frequency steps.
// - With AFC off, signed 10-bit manual offset drives synthesizer.
module afc_rate_modulation_ctrl (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic [6:0]           reg_addr,
  input  wire logic                 reg_wr_en,
  input  wire logic                 reg_rd_en,
  input  wire logic [7:0]           reg_wdata,
  output logic [7:0]                reg_rdata,
  input  wire afc_pkg::afc_radio_t  radio,
  input  wire logic signed [9:0]    freq_err,
  input  wire logic                 afc_enable,
  input  wire logic [2:0]           gear,
  input  wire logic [2:0]           cycle_wait,
  input  wire logic                 band_high,
  input  wire logic                 rate_scale,
  input  wire logic                 gpio_data,
  input  wire logic                 sdi_data,
  input  wire logic                 chip_select_n,
  input  wire logic                 fifo_bit,
  output logic                      fifo_bit_req,
  output logic [9:0]                synth_offset,
  output logic                      synth_step_double,
  output logic                      afc_frozen,
  output afc_pkg::afc_modtyp_t      mod_type,
  output logic [8:0]                deviation_word,
  output logic                      tx_data_clk_needed,
  output logic                      tx_bit,
  output logic                      tx_bit_tick
);
  import afc_pkg::*;

  typedef enum logic [1:0] {AFC_IDLE, AFC_MEAS, AFC_SETTLE, AFC_HOLD} afc_state_t;

  // Clamp to the pull-in range first, then to the shared 10-bit word
  function automatic logic signed [9:0] afc_apply(input logic signed [9:0]  corr,
                                                  input logic signed [10:0] err_sum,
                                                  input logic [2:0]         gr,
                                                  input logic [7:0]         lim);
    logic signed [11:0] step;
    logic signed [11:0] total;
    logic signed [11:0] bound;
    step  = $signed({err_sum[10], err_sum}) >>> (4'(gr) + 4'h1);
    total = $signed({{2{corr[9]}}, corr}) + step;
    bound = $signed(12'(lim) <<< LIMIT_STEP_SHIFT);
    if (total > bound) total = bound;
    if (total < -bound) total = -bound;
    if (total > CORR_MAX) total = CORR_MAX;
    if (total < CORR_MIN) total = CORR_MIN;
    return total[9:0];
  endfunction

  logic [7:0]        pull_in_limit;
  logic [7:0]        rate_hi;
  logic [7:0]        rate_lo;
  afc_mod_cfg_t      mod_cfg;
  logic [7:0]        dev_lo;
  logic [9:0]        manual_offset_word;
  afc_state_t        state;
  logic signed [9:0] afc_corr;
  logic signed [10:0] err_acc;
  logic [3:0]        bit_cnt;
  logic [3:0]        settle_len;
  logic              en_latched;
  logic              rx_prev;
  logic              rx_entry;
  logic              apply_now;
  logic              mp_clear;
  logic [8:0]        pn9;
  logic              rate_tick;
  logic              next_bit;
  logic              afc_drive;
  logic [3:0]        bits_since;
  logic              seen_apply;

  assign rx_entry   = radio.rx_active && !rx_prev;
  assign settle_len = SETTLE_PER_WAIT * 4'(cycle_wait);
  assign apply_now  = (state == AFC_MEAS) && radio.rx_bit_tick && (bit_cnt == MEAS_BITS - 4'h1)
                      && !radio.preamble_det && !radio.packet_end;
  assign mp_clear   = radio.rx_active && radio.multi_packet && radio.packet_end;
  assign afc_drive  = radio.rx_active && en_latched;

  // Register write side
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pull_in_limit      <= RST_LIMIT;
      rate_hi            <= RST_RATE_HI;
      rate_lo            <= RST_RATE_LO;
      mod_cfg            <= afc_mod_cfg_t'(RST_MOD2);
      dev_lo             <= RST_DEV;
      manual_offset_word <= {2'(RST_OFS), RST_OFS};
    end else if (reg_wr_en) begin
      case (reg_addr)
        ADDR_LIMIT:   pull_in_limit <= reg_wdata;
        ADDR_RATE_HI: rate_hi <= reg_wdata;
        ADDR_RATE_LO: rate_lo <= reg_wdata;
        ADDR_MOD2:    mod_cfg <= afc_mod_cfg_t'(reg_wdata);
        ADDR_DEV:     dev_lo <= reg_wdata;
        ADDR_OFS_LO:  manual_offset_word[7:0] <= reg_wdata;
        ADDR_OFS_HI:  manual_offset_word[9:8] <= reg_wdata[1:0];
        default:      ;
      endcase
    end
  end

  // Read side; the correction register is read-only, unmapped addresses read zero
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd_en) begin
      case (reg_addr)
        ADDR_LIMIT:   reg_rdata <= pull_in_limit;
        ADDR_CORR:    reg_rdata <= afc_corr[7:0];
        ADDR_RATE_HI: reg_rdata <= rate_hi;
        ADDR_RATE_LO: reg_rdata <= rate_lo;
        ADDR_MOD2:    reg_rdata <= mod_cfg;
        ADDR_DEV:     reg_rdata <= dev_lo;
        ADDR_OFS_LO:  reg_rdata <= manual_offset_word[7:0];
        ADDR_OFS_HI:  reg_rdata <= {6'h00, manual_offset_word[9:8]};
        default:      reg_rdata <= 8'h00;
      endcase
    end
  end

  // Enable only counts from receive entry, so a change mid-packet cannot retune the synthesizer
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rx_prev    <= 1'b0;
      en_latched <= 1'b0;
    end else begin
      rx_prev <= radio.rx_active;
      if (rx_entry) begin
        en_latched <= afc_enable;
      end
    end
  end

  // Loop sequencing: measure, correct, settle, repeat until preamble
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state   <= AFC_IDLE;
      bit_cnt <= 4'h0;
      err_acc <= '0;
    end else if (!radio.rx_active || (rx_entry && !afc_enable) || (!rx_entry && !en_latched)) begin
      state   <= AFC_IDLE;
      bit_cnt <= 4'h0;
      err_acc <= '0;
    end else if (rx_entry || mp_clear) begin
      state   <= AFC_MEAS;
      bit_cnt <= 4'h0;
      err_acc <= '0;
    end else if (radio.preamble_det) begin
      state <= AFC_HOLD;
    end else begin
      case (state)
        AFC_MEAS: begin
          if (radio.rx_bit_tick) begin
            if (apply_now) begin
              state   <= (settle_len == 4'h0) ? AFC_MEAS : AFC_SETTLE;
              bit_cnt <= 4'h0;
              err_acc <= '0;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
              err_acc <= err_acc + 11'(freq_err);
            end
          end
        end
        AFC_SETTLE: begin
          if (radio.rx_bit_tick) begin
            if (bit_cnt >= settle_len - 4'h1) begin
              state   <= AFC_MEAS;
              bit_cnt <= 4'h0;
            end else begin
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        AFC_HOLD: begin
          if (radio.packet_end) begin
            state   <= AFC_MEAS;
            bit_cnt <= 4'h0;
          end
        end
        AFC_IDLE: state <= AFC_IDLE;
        default:  state <= AFC_IDLE;
      endcase
    end
  end

  // Correction word; a packet-end clear wins over a pending correction
  always_ff @(posedge mclk) begin
    if (!rst_b || rx_entry || mp_clear) begin
      afc_corr <= '0;
    end else if (apply_now && cycle_wait != 3'h0) begin
      afc_corr <= afc_apply(afc_corr, err_acc + 11'(freq_err), gear, pull_in_limit);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      afc_frozen <= 1'b0;
    end else if (radio.rx_active && radio.preamble_det) begin
      afc_frozen <= 1'b1;
    end else if (radio.packet_end || !radio.rx_active) begin
      afc_frozen <= 1'b0;
    end
  end

  // Automatic and manual offsets share one synthesizer word
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      synth_offset      <= 10'h000;
      synth_step_double <= 1'b0;
    end else begin
      synth_offset      <= afc_drive ? afc_corr : manual_offset_word;
      synth_step_double <= band_high;
    end
  end

  afc_rate_gen #(
    .RATE_W    (16)
  ) u_rate (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .run       (radio.tx_active),
    .rate_word ({rate_hi, rate_lo}),
    .low_scale (rate_scale),
    .bit_tick  (rate_tick)
  );

  // Source selection; SDI only carries data while the serial port is deselected
  always_comb begin
    case (mod_cfg.dtmod)
      SRC_GPIO: next_bit = gpio_data;
      SRC_SDI:  next_bit = chip_select_n ? sdi_data : tx_bit ^ mod_cfg.eninv;
      SRC_FIFO: next_bit = fifo_bit;
      SRC_PN9:  next_bit = pn9[0];
      default:  next_bit = 1'b0;
    endcase
  end

  assign fifo_bit_req = rate_tick && (mod_cfg.dtmod == SRC_FIFO);

  always_ff @(posedge mclk) begin
    if (!rst_b || !radio.tx_active) begin
      pn9 <= PN9_SEED;
    end else if (rate_tick && mod_cfg.dtmod == SRC_PN9) begin
      pn9 <= {pn9[0] ^ pn9[5], pn9[8:1]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tx_bit      <= 1'b0;
      tx_bit_tick <= 1'b0;
    end else begin
      tx_bit_tick <= rate_tick;
      if (rate_tick) begin
        tx_bit <= next_bit ^ mod_cfg.eninv;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      mod_type           <= MOD_CARRIER;
      deviation_word     <= 9'h000;
      tx_data_clk_needed <= 1'b0;
    end else begin
      mod_type           <= mod_cfg.modtyp;
      deviation_word     <= {mod_cfg.dev_msb, dev_lo};
      tx_data_clk_needed <= (mod_cfg.modtyp == MOD_GFSK) && !mod_cfg.dtmod[1];
    end
  end

  // Bit periods since the last correction, for checking cycle length
  always_ff @(posedge mclk) begin
    if (!rst_b || rx_entry || radio.packet_end || !radio.rx_active) begin
      bits_since <= 4'h0;
      seen_apply <= 1'b0;
    end else if (apply_now) begin
      bits_since <= 4'h1;
      seen_apply <= 1'b1;
    end else if (radio.rx_bit_tick && bits_since != 4'hF) begin
      bits_since <= bits_since + 4'h1;
    end
  end

  chk_hold_after_pre: assert property (@(posedge mclk) disable iff (!rst_b)
    afc_frozen && !radio.packet_end && radio.rx_active && !rx_entry |=> $stable(afc_corr))
    else $error("correction moved after preamble");
  chk_mp_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    mp_clear |=> afc_corr == 10'sh000) else $error("correction not cleared at packet end");
  chk_pull_in_range: assert property (@(posedge mclk) disable iff (!rst_b)
    apply_now && cycle_wait != 3'h0 ##1 $stable(pull_in_limit)
    |-> $signed({{2{afc_corr[9]}}, afc_corr}) <= $signed(12'(pull_in_limit) <<< LIMIT_STEP_SHIFT)
        && $signed({{2{afc_corr[9]}}, afc_corr}) >= -$signed(12'(pull_in_limit) <<< LIMIT_STEP_SHIFT))
    else $error("correction outside pull-in range");
  chk_cycle_length: assert property (@(posedge mclk) disable iff (!rst_b)
    apply_now && seen_apply && !radio.preamble_det && $stable(cycle_wait)
    |-> bits_since == MEAS_BITS + settle_len) else $error("correction cycle length wrong");
  chk_wait_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    cycle_wait == 3'h0 && !rx_entry && !mp_clear |=> $stable(afc_corr))
    else $error("correction changed with wait zero");
  chk_corr_read: assert property (@(posedge mclk) disable iff (!rst_b)
    reg_rd_en && reg_addr == ADDR_CORR |=> reg_rdata == $past(afc_corr[7:0]))
    else $error("correction read mismatch");
  chk_manual_path: assert property (@(posedge mclk) disable iff (!rst_b)
    !afc_drive |=> synth_offset == $past(manual_offset_word)) else $error("manual offset not applied");
  chk_auto_path: assert property (@(posedge mclk) disable iff (!rst_b)
    afc_drive |=> synth_offset == $past(afc_corr)) else $error("automatic correction not applied");
  chk_enable_latch: assert property (@(posedge mclk) disable iff (!rst_b)
    radio.rx_active && !rx_entry |=> $stable(en_latched)) else $error("enable changed inside receive");
  chk_pn9_source: assert property (@(posedge mclk) disable iff (!rst_b)
    rate_tick && mod_cfg.dtmod == SRC_PN9 |=> tx_bit == ($past(pn9[0]) ^ $past(mod_cfg.eninv)))
    else $error("pn9 bit not sent");
  chk_gfsk_clock: assert property (@(posedge mclk) disable iff (!rst_b)
    mod_cfg.modtyp == MOD_GFSK && mod_cfg.dtmod == SRC_GPIO |=> tx_data_clk_needed)
    else $error("gfsk direct without data clock");

  cov_apply: cover property (@(posedge mclk) disable iff (!rst_b) apply_now ##[1:200] apply_now);
  cov_freeze: cover property (@(posedge mclk) disable iff (!rst_b) apply_now ##[1:200] afc_frozen);
  cov_mp_restart: cover property (@(posedge mclk) disable iff (!rst_b) mp_clear ##[1:200] apply_now);
  cov_tx_bits: cover property (@(posedge mclk) disable iff (!rst_b) tx_bit_tick ##[1:1000] tx_bit_tick);

endmodule

// ---- testbench/afc_rate_modulation_ctrl_test.sv ----
// Purpose: Self-checking bench for the AFC, rate and modulation control block
// Assumes: Registers reached through the strobe port; remote side modelled
// Notes:   Low-rate scale case needs 12800 cycles per bit, the longest wait here
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module afc_rate_modulation_ctrl_test;
  import afc_pkg::*;
  logic mclk = 0, rst_b = 0, reg_wr_en = 0, reg_rd_en = 0, rx = 0, tx = 0, pend = 0, multi = 1;
  logic afc_enable = 1, band_high = 0, rate_scale = 0, gpio_data = 1, sdi_data = 0, chip_select_n = 1, fifo_bit = 1;
  logic [6:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, d;
  logic [2:0] gear = 0, cycle_wait = 1;
  logic [9:0] err_val = 0, freq_err, synth_offset, off;
  logic tick, pre, synth_step_double, afc_frozen, tx_data_clk_needed, tx_bit, tx_bit_tick, req;
  logic [8:0] dev;
  afc_modtyp_t mod_type;
  afc_radio_t radio;
  int error_cnt = 0, tests_run = 0, c, k, c0, nreq = 0;
  logic [7:0] lim_t [5] = '{8'hFF, 8'h01, 8'h80, 8'hFF, 8'hFF};
  logic [2:0] gear_t [5] = '{0, 0, 0, 1, 0};
  logic [2:0] wait_t [5] = '{1, 1, 1, 1, 0};
  logic [9:0] err_t [5] = '{10'd30, 10'd20, 10'h39C, 10'd40, 10'd40};
  logic [7:0] exp_t [5] = '{8'h1E, 8'h04, 8'h9C, 8'h14, 8'h00};
  logic [7:0] src_t [4] = '{8'h22, 8'h0A, 8'h12, 8'h32};
  logic       bit_t [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
  assign radio = '{rx, tx, pre, pend, multi, tick};
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) if (req === 1'b1) nreq++;
  afc_remote_tx remote (.mclk(mclk), .rst_b(rst_b), .rx_on(rx), .afc_on(afc_enable), .err_val(err_val),
    .bit_tick(tick), .preamble_seen(pre), .freq_err(freq_err));
  afc_rate_modulation_ctrl uut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .radio(radio), .freq_err(freq_err),
    .afc_enable(afc_enable), .gear(gear), .cycle_wait(cycle_wait), .band_high(band_high),
    .rate_scale(rate_scale), .gpio_data(gpio_data), .sdi_data(sdi_data), .chip_select_n(chip_select_n),
    .fifo_bit(fifo_bit), .fifo_bit_req(req), .synth_offset(synth_offset), .synth_step_double(synth_step_double),
    .afc_frozen(afc_frozen), .mod_type(mod_type), .deviation_word(dev), .tx_data_clk_needed(tx_data_clk_needed),
    .tx_bit(tx_bit), .tx_bit_tick(tx_bit_tick));
  task close_out; begin
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  end endtask
  task hang; begin
    error_cnt++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  end endtask
  task wr(input logic [6:0] a, input logic [7:0] v); begin
    @(negedge mclk) {reg_addr, reg_wdata, reg_wr_en} = {a, v, 1'b1};
    @(negedge mclk) reg_wr_en = 0;
  end endtask
  task rd(input logic [6:0] a, output logic [7:0] v); begin
    @(negedge mclk) {reg_addr, reg_rd_en} = {a, 1'b1};
    @(negedge mclk) reg_rd_en = 0;
    @(negedge mclk) v = reg_rdata;
  end endtask
  // Received bit ticks come from the remote model, sampled away from its drive edge
  task ticks(input int n); begin
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin @(posedge mclk); k++; end while (tick !== 1'b1 && k < 50);
      if (k >= 50) hang();
    end
  end endtask
  task gap(output int g); begin
    g = 0;
    do begin @(negedge mclk); g++; end while (tx_bit_tick !== 1'b1 && g < 20000);
    if (g >= 20000) hang();
  end endtask
  initial begin
    repeat (3) @(negedge mclk);
    rst_b = 1;
    rd(7'h6E, d); `CHK(d, 8'h0A)
    rd(7'h6F, d); `CHK(d, 8'h3D)
    rd(7'h71, d); `CHK(d, 8'h00)
    rd(7'h10, d); `CHK(d, 8'h00)
    for (int i = 0; i < 5; i++) begin
      rx = 0;
      wr(ADDR_LIMIT, lim_t[i]);
      {gear, cycle_wait, err_val} = {gear_t[i], wait_t[i], err_t[i]};
      @(negedge mclk) rx = 1;
      ticks(3);
      rd(ADDR_CORR, d); `CHK(d, exp_t[i])
    end
    rx = 0;
    {gear, cycle_wait, err_val} = {3'h0, 3'h1, 10'd30};
    wr(ADDR_LIMIT, 8'hFF);
    @(negedge mclk) rx = 1;
    ticks(3);
    @(negedge mclk) `CHK(synth_offset, 10'd30)
    band_high = 1;
    @(negedge mclk) `CHK(synth_step_double, 1'b1)
    band_high = 0;
    k = 0;
    while (afc_frozen !== 1'b1 && k < 1000) begin @(negedge mclk); k++; end
    if (k >= 1000) hang();
    off = synth_offset;
    // Ten four-bit cycles complete before the 40th bit
    `CHK(off, 10'd300)
    ticks(8);
    @(negedge mclk) `CHK(synth_offset, off)
    pend = 1;
    @(negedge mclk) pend = 0;
    rd(ADDR_CORR, d); `CHK(d, 8'h00)
    `CHK(afc_frozen, 1'b0)
    rx = 0;
    afc_enable = 0;
    wr(ADDR_OFS_LO, 8'h5A);
    wr(ADDR_OFS_HI, 8'h03);
    @(negedge mclk) rx = 1;
    // Enable rises only after the entry edge, so the loop must stay off
    @(negedge mclk) afc_enable = 1;
    ticks(6);
    @(negedge mclk) `CHK(synth_offset, 10'h35A)
    rd(ADDR_OFS_HI, d); `CHK(d, 8'h03)
    rx = 0;
    tx = 1;
    repeat (3) @(negedge mclk);
    `CHK(synth_offset, 10'h35A)
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_MOD2, {6'h00, 2'(m)});
      repeat (2) @(negedge mclk);
      `CHK(mod_type, 2'(m))
      `CHK(tx_data_clk_needed, m == 3)
    end
    // 62.5 kbps: above the scale threshold, below the high-rate modem setting
    wr(ADDR_RATE_HI, 8'h10);
    wr(ADDR_RATE_LO, 8'h00);
    // Buffer, pin with inversion, serial input while deselected, internal sequence
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_MOD2, src_t[s]);
      c0 = nreq;
      gap(c);
      gap(c);
      `CHK(c, 3200)
      `CHK(tx_bit, bit_t[s])
      `CHK(nreq - c0, (s == 0) ? 2 : 0)
      `CHK(dev, {src_t[s][2], RST_DEV})
    end
    // 15.625 kbps needs the low-rate scale
    wr(ADDR_RATE_HI, 8'h80);
    rate_scale = 1;
    gap(c);
    gap(c);
    `CHK(c, 12800)
    close_out();
  end
endmodule

// ---- testbench/afc_remote_tx.sv ----
// Purpose: Remote transmitter as the receiver sees it: bit ticks, error samples, preamble detect
// Assumes: One received bit every 8 mclk cycles while receiving
// Notes:   Error line shows the inverse between bit ticks so a stale sample cannot pass
`timescale 1ns/1ps
module afc_remote_tx (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        rx_on,
  input  wire logic        afc_on,
  input  wire logic [9:0]  err_val,
  output logic             bit_tick,
  output logic             preamble_seen,
  output logic [9:0]       freq_err
);
  logic [2:0] ph;
  logic [7:0] nbits;
  always @(negedge mclk) begin
    if (!rst_b || !rx_on) begin
      ph            <= 3'h0;
      nbits         <= 8'h00;
      bit_tick      <= 1'b0;
      preamble_seen <= 1'b0;
      freq_err      <= ~err_val;
    end else begin
      ph            <= ph + 3'h1;
      bit_tick      <= (ph == 3'h7);
      freq_err      <= (ph == 3'h7) ? err_val : ~err_val;
      // Longer preamble when the far loop needs settling time
      preamble_seen <= (ph == 3'h7) && (nbits + 8'h01 == (afc_on ? 8'd40 : 8'd32));
      if (ph == 3'h7) begin
        nbits <= nbits + 8'h01;
      end
    end
  end
endmodule
